/* File: verilog/adc_pipe_pkg.sv */
// Constants for the flash converter output pipeline
`default_nettype none
package adc_pipe_pkg;

  // ---------------------------------------------------------------
  // Datapath geometry
  // ---------------------------------------------------------------
  localparam int CMP_N   = 256;
  localparam int COL_N   = 4;
  localparam int COL_W   = 64;
  localparam int CNT_W   = 7;
  localparam int LOW_W   = 6;
  localparam int DATA_W  = 8;
  localparam int SUM_W   = 9;
  localparam int FCNT_W  = 3;
  localparam int MSB_BIT = 7;

  localparam logic [CNT_W-1:0]  COL_FULL_CNT = 7'h40;
  localparam logic [FCNT_W-1:0] ALL_COLS     = 3'h4;
  localparam logic [DATA_W-1:0] FULL_SCALE   = 8'hFF;
  localparam logic [DATA_W-1:0] LOW_MASK     = 8'h7F;
  localparam logic [DATA_W-1:0] MSB_MASK     = 8'h80;
  localparam logic [SUM_W-1:0]  SUM_SAT      = 9'h0FF;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int REG_W  = 32;

  localparam logic [ADDR_W-1:0] OFS_CTRL       = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SAMPLE     = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h10;

  localparam int CTRL_LOW_INV = 0;
  localparam int CTRL_MSB_INV = 1;
  localparam int CTRL_DV_POL  = 2;
  localparam int SAMPLE_OVR   = 8;

  localparam int IRQ_W      = 2;
  localparam int IRQ_OVR    = 0;
  localparam int IRQ_BUBBLE = 1;

  localparam logic [IRQ_W-1:0]  IRQ_RST  = 2'h0;
  localparam logic [REG_W-1:0]  RDATA_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

endpackage
`default_nettype wire

/* File: verilog/column_decoder.sv */
// One 64-input thermometer column reduced to a tripped count
`timescale 1ns/1ps
`default_nettype none
module column_decoder (
  input  wire logic [adc_pipe_pkg::COL_W-1:0] therm,
  output logic      [adc_pipe_pkg::CNT_W-1:0] count,
  output logic                                full
);

  // ---------------------------------------------------------------
  // Count of ones; a bubble costs at most one code
  // ---------------------------------------------------------------
  always_comb begin
    count = '0;
    for (int i = 0; i < adc_pipe_pkg::COL_W; i++) begin
      count = count + adc_pipe_pkg::CNT_W'(therm[i]);
    end
  end

  assign full = (count == adc_pipe_pkg::COL_FULL_CNT);

endmodule
`default_nettype wire

/* File: verilog/flash_adc_output_pipeline.sv */
// Output pipeline of the flash converter with its register port
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module flash_adc_output_pipeline (
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic [adc_pipe_pkg::CMP_N-1:0]    thresh_trip,
  output logic      [adc_pipe_pkg::DATA_W-1:0]   sample_data,
  output logic                                   overrange_bit,
  output logic                                   data_valid_flag,
  input  wire logic [adc_pipe_pkg::ADDR_W-1:0]   addr,
  input  wire logic [adc_pipe_pkg::REG_W-1:0]    wdata,
  input  wire logic                              wr,
  input  wire logic                              rd,
  output logic      [adc_pipe_pkg::REG_W-1:0]    rdata,
  output logic                                   irq
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [adc_pipe_pkg::CMP_N-1:0]  frz_r;
  logic                            frz_vld_r;
  logic [adc_pipe_pkg::CNT_W-1:0]  col_cnt [adc_pipe_pkg::COL_N];
  logic [adc_pipe_pkg::COL_N-1:0]  col_full;
  logic [adc_pipe_pkg::FCNT_W-1:0] full_cnt;
  logic [1:0]                      act_col;
  logic [adc_pipe_pkg::LOW_W-1:0]  low_field;
  logic                            ovr_nxt;
  logic                            bubble_nxt;
  logic [adc_pipe_pkg::DATA_W-1:0] code_nxt;
  logic [adc_pipe_pkg::DATA_W-1:0] xor_nxt;
  logic [adc_pipe_pkg::SUM_W-1:0]  trip_sum;
  logic                            low_sel_r;
  logic                            msb_sel_r;
  logic                            pol_sel_r;
  logic [adc_pipe_pkg::DATA_W-1:0] sample_data_r;
  logic                            overrange_bit_r;
  logic                            dv_tog_r;
  logic                            dv_tog_nxt;
  logic                            data_valid_flag_r;
  logic [adc_pipe_pkg::IRQ_W-1:0]  irq_status_r;
  logic [adc_pipe_pkg::IRQ_W-1:0]  irq_status_nxt;
  logic [adc_pipe_pkg::IRQ_W-1:0]  irq_en_r;
  logic [adc_pipe_pkg::IRQ_W-1:0]  irq_en_nxt;
  logic [adc_pipe_pkg::IRQ_W-1:0]  irq_events;
  logic [adc_pipe_pkg::IRQ_W-1:0]  irq_clr;
  logic                            irq_r;
  logic [adc_pipe_pkg::REG_W-1:0]  rdata_r;
  logic [adc_pipe_pkg::REG_W-1:0]  rdata_nxt;
  logic                            wr_ctrl;
  logic                            wr_en;
  logic                            wr_clr;

  // ---------------------------------------------------------------
  // Comparator freeze
  // ---------------------------------------------------------------
  // Decisions track the input until the edge; the edge holds them.
  always_ff @(posedge clk) begin
    frz_r <= thresh_trip;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      frz_vld_r <= 1'b0;
    end else begin
      frz_vld_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Column decoders
  // ---------------------------------------------------------------
  // Falling-edge decode and latch stages fold into the cycle after the
  // freeze, since this block runs on one edge only.
  generate
    for (genvar c = 0; c < adc_pipe_pkg::COL_N; c++) begin : g_col
      column_decoder u_dec (
        .therm (frz_r[c*adc_pipe_pkg::COL_W +: adc_pipe_pkg::COL_W]),
        .count (col_cnt[c]),
        .full  (col_full[c])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Column merge
  // ---------------------------------------------------------------
  always_comb begin
    full_cnt   = '0;
    bubble_nxt = 1'b0;
    for (int c = 0; c < adc_pipe_pkg::COL_N; c++) begin
      full_cnt = full_cnt + adc_pipe_pkg::FCNT_W'(col_full[c]);
    end
    for (int c = 1; c < adc_pipe_pkg::COL_N; c++) begin
      if (!col_full[c-1] && (col_cnt[c] != '0)) begin
        bubble_nxt = 1'b1;
      end
    end
    act_col   = full_cnt[1:0];
    low_field = col_cnt[act_col][adc_pipe_pkg::LOW_W-1:0];
    ovr_nxt   = (full_cnt == adc_pipe_pkg::ALL_COLS);
    if (ovr_nxt) begin
      code_nxt = adc_pipe_pkg::FULL_SCALE;
    end else begin
      code_nxt = {act_col, low_field};
    end
  end

  // Plain tripped count, used only to check the merge
  always_comb begin
    trip_sum = '0;
    for (int c = 0; c < adc_pipe_pkg::COL_N; c++) begin
      trip_sum = trip_sum + adc_pipe_pkg::SUM_W'(col_cnt[c]);
    end
  end

  // ---------------------------------------------------------------
  // Output inversion, one XOR per bit
  // ---------------------------------------------------------------
  generate
    for (genvar b = 0; b < adc_pipe_pkg::DATA_W; b++) begin : g_xor
      if (b == adc_pipe_pkg::MSB_BIT) begin : g_msb
        assign xor_nxt[b] = code_nxt[b] ^ msb_sel_r;
      end else begin : g_low
        assign xor_nxt[b] = code_nxt[b] ^ low_sel_r;
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Output stages
  // ---------------------------------------------------------------
  // Bit 0 of sample_data is the LSB, bit 7 the MSB.
  always_ff @(posedge clk) begin
    if (rst) begin
      sample_data_r <= adc_pipe_pkg::DATA_RST;
    end else begin
      sample_data_r <= xor_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      overrange_bit_r <= 1'b0;
    end else begin
      overrange_bit_r <= ovr_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Data-valid flag
  // ---------------------------------------------------------------
  // Toggles with every new sample while the polarity select holds, so the receiver can latch on either edge.
  assign dv_tog_nxt = frz_vld_r ? ~dv_tog_r : dv_tog_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      dv_tog_r          <= 1'b0;
      data_valid_flag_r <= 1'b0;
    end else begin
      dv_tog_r          <= dv_tog_nxt;
      data_valid_flag_r <= dv_tog_nxt ^ pol_sel_r;
    end
  end

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  assign wr_ctrl = wr && (addr == adc_pipe_pkg::OFS_CTRL);
  assign wr_en   = wr && (addr == adc_pipe_pkg::OFS_IRQ_ENABLE);
  assign wr_clr  = wr && (addr == adc_pipe_pkg::OFS_IRQ_CLEAR);

  always_ff @(posedge clk) begin
    if (rst) begin
      low_sel_r <= 1'b0;
      msb_sel_r <= 1'b0;
      pol_sel_r <= 1'b0;
    end else if (wr_ctrl) begin
      low_sel_r <= wdata[adc_pipe_pkg::CTRL_LOW_INV];
      msb_sel_r <= wdata[adc_pipe_pkg::CTRL_MSB_INV];
      pol_sel_r <= wdata[adc_pipe_pkg::CTRL_DV_POL];
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  // A new event beats a clear in the same cycle.
  always_comb begin
    irq_events                          = '0;
    irq_events[adc_pipe_pkg::IRQ_OVR]    = frz_vld_r && ovr_nxt;
    irq_events[adc_pipe_pkg::IRQ_BUBBLE] = frz_vld_r && bubble_nxt;
    irq_clr        = wr_clr ? wdata[adc_pipe_pkg::IRQ_W-1:0] : '0;
    irq_status_nxt = (irq_status_r & ~irq_clr) | irq_events;
    irq_en_nxt     = wr_en ? wdata[adc_pipe_pkg::IRQ_W-1:0] : irq_en_r;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_status_r <= adc_pipe_pkg::IRQ_RST;
      irq_en_r     <= adc_pipe_pkg::IRQ_RST;
      irq_r        <= 1'b0;
    end else begin
      irq_status_r <= irq_status_nxt;
      irq_en_r     <= irq_en_nxt;
      irq_r        <= |(irq_status_nxt & irq_en_nxt);
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  // Status reads show the state before this cycle's write; the clear
  // register and unmapped addresses read as zero.
  always_comb begin
    rdata_nxt = '0;
    if (rd) begin
      case (addr)
        adc_pipe_pkg::OFS_CTRL: begin
          rdata_nxt[adc_pipe_pkg::CTRL_LOW_INV] = low_sel_r;
          rdata_nxt[adc_pipe_pkg::CTRL_MSB_INV] = msb_sel_r;
          rdata_nxt[adc_pipe_pkg::CTRL_DV_POL]  = pol_sel_r;
        end
        adc_pipe_pkg::OFS_SAMPLE: begin
          rdata_nxt[adc_pipe_pkg::DATA_W-1:0]   = sample_data_r;
          rdata_nxt[adc_pipe_pkg::SAMPLE_OVR]   = overrange_bit_r;
        end
        adc_pipe_pkg::OFS_IRQ_STATUS: begin
          rdata_nxt[adc_pipe_pkg::IRQ_W-1:0]    = irq_status_r;
        end
        adc_pipe_pkg::OFS_IRQ_ENABLE: begin
          rdata_nxt[adc_pipe_pkg::IRQ_W-1:0]    = irq_en_r;
        end
        default: begin
          rdata_nxt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= adc_pipe_pkg::RDATA_RST;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign sample_data     = sample_data_r;
  assign overrange_bit   = overrange_bit_r;
  assign data_valid_flag = data_valid_flag_r;
  assign rdata           = rdata_r;
  assign irq             = irq_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_all_taken;
    &thresh_trip;
  endsequence

  sequence s_all_frozen;
    frz_vld_r && (&frz_r);
  endsequence

  sequence s_clean_sample;
    frz_vld_r && !bubble_nxt && !ovr_nxt;
  endsequence

  sequence s_steady_pol;
    frz_vld_r && $stable(pol_sel_r);
  endsequence

  AST_TAKE_TO_OUT:
    assert property (s_all_taken |=> ##1 (overrange_bit_r && frz_vld_r))
      else $error("Overrange not shown one cycle after sampling");

  AST_OVR_FLAG:
    assert property (s_all_frozen |=> overrange_bit_r)
      else $error("All thresholds tripped but no overrange");

  AST_OVR_DATA:
    assert property (s_all_frozen ##0 (!low_sel_r && !msb_sel_r)
                     |=> (sample_data_r == adc_pipe_pkg::FULL_SCALE))
      else $error("Overrange sample not full scale");

  AST_LOW_INV:
    assert property (frz_vld_r |=> (((sample_data_r ^ $past(code_nxt))
                     & adc_pipe_pkg::LOW_MASK) == ($past(low_sel_r) ?
                     adc_pipe_pkg::LOW_MASK : 8'h00)))
      else $error("Low bits inversion wrong");

  AST_MSB_INV:
    assert property (frz_vld_r |=> (((sample_data_r ^ $past(code_nxt))
                     & adc_pipe_pkg::MSB_MASK) == ($past(msb_sel_r) ?
                     adc_pipe_pkg::MSB_MASK : 8'h00)))
      else $error("Top bit inversion wrong");

  AST_STRAIGHT:
    assert property (s_clean_sample ##0 (!low_sel_r && !msb_sel_r)
                     |=> (sample_data_r == $past(trip_sum[adc_pipe_pkg::DATA_W-1:0])))
      else $error("Straight binary is not the tripped count");

  AST_TWOS:
    assert property (s_clean_sample ##0 (!low_sel_r && msb_sel_r)
                     |=> ((sample_data_r ^ adc_pipe_pkg::MSB_MASK)
                     == $past(trip_sum[adc_pipe_pkg::DATA_W-1:0])))
      else $error("Two's complement code wrong");

  AST_SAT:
    assert property ((frz_vld_r && (trip_sum > adc_pipe_pkg::SUM_SAT))
                     ##0 (!low_sel_r && !msb_sel_r) |=> (&sample_data_r))
      else $error("Count does not saturate");

  AST_DV_TOGGLE:
    assert property (s_steady_pol |=> (data_valid_flag_r != $past(data_valid_flag_r)))
      else $error("Data-valid flag failed to toggle");

  AST_INV_DEFAULT:
    assert property ($fell(rst) |-> (!low_sel_r && !msb_sel_r))
      else $error("Inversion selects not low after reset");

endmodule
`default_nettype wire

/* File: tb/capture_model.sv */
// Capture logic that latches each output sample on a data-valid flag change
`timescale 1ns/1ps
`default_nettype none
module capture_model (
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic [adc_pipe_pkg::DATA_W-1:0]   sample_data,
  input  wire logic                              overrange_bit,
  input  wire logic                              data_valid_flag,
  output logic      [adc_pipe_pkg::DATA_W:0]     cap_data,
  output logic      [15:0]                       cap_cnt
);
  logic flag_prev_r;

  // Any edge of the flag marks new data, whatever the polarity
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_prev_r <= 1'b0;
      cap_data    <= '0;
      cap_cnt     <= 16'h0;
    end else begin
      flag_prev_r <= data_valid_flag;
      if (data_valid_flag != flag_prev_r) begin
        cap_data <= {overrange_bit, sample_data};
        cap_cnt  <= cap_cnt + 16'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the converter output pipeline
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic [255:0] thresh_trip;
  logic [7:0]   addr;
  logic [31:0]  wdata;
  logic         wr;
  logic         rd;
  logic [7:0]   sample_data;
  logic         overrange_bit;
  logic         data_valid_flag;
  logic [31:0]  rdata;
  logic         irq;
  logic [8:0]   cap_data;
  logic [15:0]  cap_cnt;
  integer       seed = 13;
  int           n_mismatch = 0;
  int           num_checks = 0;
  logic [2:0]   ctrl;
  int           hold_lvl;
  logic [31:0]  v;
  logic         dv_seen;
  logic [8:0]   q[$];
  int           corner[11] = '{0, 1, 63, 64, 65, 127, 128, 191, 192, 255, 256};

  always #20 clk = ~clk;

  flash_adc_output_pipeline flash_adc_output_pipeline_i (.clk(clk), .rst(rst),
    .thresh_trip(thresh_trip), .sample_data(sample_data), .overrange_bit(overrange_bit),
    .data_valid_flag(data_valid_flag), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq));
  capture_model capture_model_i (.clk(clk), .rst(rst), .sample_data(sample_data),
    .overrange_bit(overrange_bit), .data_valid_flag(data_valid_flag),
    .cap_data(cap_data), .cap_cnt(cap_cnt));

  // ---------------------------------------------------------------
  // Expectations
  // ---------------------------------------------------------------
  function automatic logic [255:0] therm(int lvl);
    return (lvl >= 256) ? '1 : ((256'h1 << lvl) - 256'h1);
  endfunction

  // Full count saturates to the top code; overrange stays a true flag
  function automatic logic [8:0] exp_out(int lvl, logic [2:0] c);
    logic [7:0] code;
    code = (lvl >= 255) ? 8'hFF : 8'(lvl);
    code = code ^ {c[1], {7{c[0]}}};
    return {(lvl == 256), code};
  endfunction

  // ---------------------------------------------------------------
  // Drivers and comparison
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic set_lvl(input logic [255:0] t, input int lvl);
    @(posedge clk);
    thresh_trip <= t;
    hold_lvl = lvl;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // New sample every cycle; each output checked two edges after its drive
  task automatic stream(input int n);
    int          lvl;
    logic [8:0]  e;
    logic [8:0]  last_e;
    logic [15:0] c0;
    // Let this edge's capture land first, or the count runs one ahead
    #1;
    q = {exp_out(hold_lvl, ctrl), exp_out(hold_lvl, ctrl)};
    last_e = q[0];
    c0 = cap_cnt;
    for (int i = 0; i < n; i++) begin
      lvl = (i < 11) ? corner[i] : {$random(seed)} % 257;
      @(posedge clk);
      thresh_trip <= therm(lvl);
      q.push_back(exp_out(lvl, ctrl));
      #1 e = q.pop_front();
      chk({23'h0, overrange_bit, sample_data}, {23'h0, e}, "sample");
      chk({23'h0, cap_data}, {23'h0, last_e}, "captured sample");
      last_e = e;
    end
    hold_lvl = lvl;
    chk({16'h0, cap_cnt}, {16'h0, c0 + 16'(n)}, "valid flag toggles");
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    thresh_trip = '0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    ctrl = 3'h0;
    hold_lvl = 0;
    repeat (20) @(posedge clk);
    #1 chk({21'h0, irq, data_valid_flag, overrange_bit, sample_data}, 32'h0, "reset outputs");
    chk(rdata, 32'h0, "reset read data");
    @(posedge clk);
    rst <= 1'b0;
    rd_reg(adc_pipe_pkg::OFS_CTRL, v);
    chk(v, 32'h0, "control default");
    rd_reg(adc_pipe_pkg::OFS_IRQ_ENABLE, v);
    chk(v, 32'h0, "enable default");
    rd_reg(adc_pipe_pkg::OFS_IRQ_STATUS, v);
    chk(v, 32'h0, "status default");
    rd_reg(adc_pipe_pkg::OFS_IRQ_CLEAR, v);
    chk(v, 32'h0, "clear reads zero");
    rd_reg(8'h14, v);
    chk(v, 32'h0, "unmapped read");
    set_lvl(therm(0), 0);
    // All four output codings, corners first then random levels
    for (int m = 0; m < 5; m++) begin
      ctrl = (m == 4) ? 3'h4 : m[2:0];
      wr_reg(adc_pipe_pkg::OFS_CTRL, {29'h0, ctrl});
      rd_reg(adc_pipe_pkg::OFS_CTRL, v);
      chk(v, {29'h0, ctrl}, "control readback");
      repeat (3) @(posedge clk);
      stream(60);
    end
    wr_reg(adc_pipe_pkg::OFS_SAMPLE, 32'h1FF);
    rd_reg(adc_pipe_pkg::OFS_SAMPLE, v);
    chk(v, {23'h0, exp_out(hold_lvl, ctrl)}, "sample register");
    // Interrupt raise, mask, clear
    ctrl = 3'h0;
    wr_reg(adc_pipe_pkg::OFS_CTRL, 32'h0);
    // Polarity flip cancels one toggle, then toggling resumes
    #1 dv_seen = data_valid_flag;
    @(posedge clk);
    #1 chk({31'h0, data_valid_flag}, {31'h0, dv_seen}, "polarity flip");
    @(posedge clk);
    #1 chk({31'h0, data_valid_flag}, {31'h0, ~dv_seen}, "toggle after flip");
    set_lvl(therm(10), 10);
    wr_reg(adc_pipe_pkg::OFS_IRQ_CLEAR, 32'h3);
    rd_reg(adc_pipe_pkg::OFS_IRQ_STATUS, v);
    chk(v, 32'h0, "status cleared");
    wr_reg(adc_pipe_pkg::OFS_IRQ_ENABLE, 32'h3);
    set_lvl(therm(256), 256);
    chk({31'h0, irq}, 32'h1, "irq on overrange");
    set_lvl(therm(10), 10);
    rd_reg(adc_pipe_pkg::OFS_IRQ_STATUS, v);
    chk(v, 32'h1, "overrange status");
    wr_reg(adc_pipe_pkg::OFS_IRQ_ENABLE, 32'h2);
    repeat (2) @(posedge clk);
    #1 chk({31'h0, irq}, 32'h0, "irq masked");
    set_lvl(256'h1 << 64, 1);
    chk({31'h0, (sample_data > 8'h02)}, 32'h0, "bubble within one code");
    set_lvl(therm(10), 10);
    chk({31'h0, irq}, 32'h1, "irq on bubble");
    rd_reg(adc_pipe_pkg::OFS_IRQ_STATUS, v);
    chk(v, 32'h3, "bubble status");
    wr_reg(adc_pipe_pkg::OFS_IRQ_CLEAR, 32'h3);
    rd_reg(adc_pipe_pkg::OFS_IRQ_STATUS, v);
    chk(v, 32'h0, "status after clear");
    @(posedge clk);
    #1 chk({31'h0, irq}, 32'h0, "irq after clear");
    end_sim();
  end
endmodule
`default_nettype wire
